//--- inc/isact_pkg.sv
// Purpose: Shared constants and types for the IOM-2 slave activation and TIC arbiter.
// Assumes: 40 MHz system clock; one bus bit per bit clock period; 8-bit register port.
// Notes: Frame positions of the TIC field are constants here so that a bench can find them.
package isact_pkg;

    // ****************************************
    // Register port and offsets
    // ****************************************
    localparam int REG_AW = 8;
    localparam int REG_DW = 8;
    localparam logic [REG_AW-1:0] REG_PCTL1 = 8'h00;
    localparam logic [REG_AW-1:0] REG_PCTL3 = 8'h04;
    localparam logic [REG_AW-1:0] REG_PSTAT = 8'h08;
    localparam logic [REG_AW-1:0] REG_CCH0 = 8'h0c;
    localparam logic [REG_AW-1:0] REG_LSTAT = 8'h10;

    // ****************************************
    // Field positions and reset values
    // ****************************************
    localparam int PCTL1_MODE_LSB = 0;
    localparam int PCTL1_ACT_BIT = 2;
    localparam int PCTL3_ADDR_LSB = 0;
    localparam int PCTL3_TIC_EN_BIT = 3;
    localparam int PSTAT_TREQ_BIT = 6;
    localparam int CCH0_CMD_LSB = 0;
    localparam int CCH0_BAR_BIT = 7;
    localparam int LSTAT_ACTIVE_BIT = 0;
    localparam int LSTAT_GRANT_BIT = 1;
    localparam int LSTAT_BAC_BIT = 2;
    localparam int LSTAT_HOLD_BIT = 3;
    localparam logic [1:0] MODE_RST = 2'h1;
    localparam logic [1:0] MODE_SLAVE = 2'h2;
    localparam logic [2:0] TIC_ADDR_RST = 3'h0;
    localparam logic [6:0] CCH0_CMD_RST = 7'h00;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 25;
    localparam int LOSS_TIME_NS = 650;
    localparam int LOSS_CYCLES = (LOSS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LOSS_W = $clog2(LOSS_CYCLES + 1);

    // ****************************************
    // Frame layout of the TIC field
    // ****************************************
    localparam int BIT_CNT_W = 7;
    localparam logic [BIT_CNT_W-1:0] TIC_BAC_POS = 7'h5a;
    localparam logic [BIT_CNT_W-1:0] TIC_TAD_POS = 7'h5d;
    localparam logic [BIT_CNT_W-1:0] TIC_TAD_LAST = 7'h5f;
    localparam logic [1:0] FREE_FRAMES = 2'h2;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {
        LINK_DEACT = 2'b01,
        LINK_ACTIVE = 2'b10
    } isact_link_t;

    typedef enum logic [4:0] {
        ARB_IDLE = 5'b00001,
        ARB_WAIT = 5'b00010,
        ARB_SEND = 5'b00100,
        ARB_CONFIRM = 5'b01000,
        ARB_OWN = 5'b10000
    } isact_arb_t;

    // Pin levels that cross into the system clock together
    typedef struct packed {
        logic bclk;
        logic fsync;
        logic line;
    } isact_pins_t;

    // Software-written settings
    typedef struct packed {
        logic [1:0] mode;
        logic act;
        logic tic_en;
        logic [2:0] tic_addr;
        logic bar;
        logic [6:0] ci0_cmd;
    } isact_cfg_t;

endpackage

//--- core/isact_sync2.sv
// Purpose: Two-flop synchroniser for a bundle of asynchronous pin levels.
// Assumes: Inputs are levels; only the second stage is visible outside.
// Notes: Adds two system clocks of latency to every sampled pin.
`timescale 1ns/1ps
module isact_sync2
#(
    parameter int WIDTH = 3
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s1;
    } isact_sync_st_t;

    isact_sync_st_t st_r;
    isact_sync_st_t st_nxt;

    // First stage feeds only the second stage
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.s1 = async_in;
        st_nxt.s2 = st_r.s1;
    end

    // Registers
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign sync_out = st_r.s2;
endmodule

//--- core/isact_top.sv
// Purpose: IOM-2 downstream clock-loss detection, activation and TIC bus arbitration.
// Assumes: Bus bit clock and frame sync come from the upstream device; system clock is independent.
// Notes: Open-drain data pin is driven low only; a high level comes from the external pullup.
//
// Contract
// - Clock silent 650 ns means deactivate.
// - Deactivated: pins released, watch clock rising.
// - Activation bit drives upstream data low.
// - Clock rising after deactivation sets request flag.
// - Upstream activation starts transfer without processor.
// - Request bit arbitrates when TIC enabled.
// - Three-bit TIC address is bus identity.
// - Wait for BAC one, then send address.
// - Matching sampled address claims bus, BAC zero.
// - Recheck one frame; mismatch releases, restarts.
// - Win grants D and C/I0 together.
// - Clearing request bit releases unless D busy.
// - D-channel controller requests access automatically.
// - D-channel end releases unless request bit set.
// - New access needs BAC one twice.
// - Activation bit holds pin low until cleared.
// - Status read clears timing request flag.
`timescale 1ns/1ps
module isact_top
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [isact_pkg::REG_AW-1:0] reg_addr,
    input wire logic [isact_pkg::REG_DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [isact_pkg::REG_DW-1:0] reg_rdata,
    input wire logic bit_clk_in,
    input wire logic frame_sync_in,
    input wire logic serial_port_pin_in_i,
    output logic serial_port_pin_in_o,
    output logic serial_port_pin_in_oe,
    output logic serial_port_pin_out_o,
    output logic serial_port_pin_out_oe,
    input wire logic d_channel_link_controller_req,
    output logic tic_bus_granted,
    output logic [6:0] command_channel0_tx_code,
    output logic link_active,
    output logic timing_request_irq
);
    import isact_pkg::*;

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        isact_link_t link;
        isact_arb_t arb;
        isact_cfg_t cfg;
        logic treq;
        logic [REG_DW-1:0] rdata;
        logic bclk_d;
        logic [LOSS_W-1:0] loss_cnt;
        logic [BIT_CNT_W-1:0] bit_cnt;
        logic line_bac;
        logic [2:0] tad_rx;
        logic lost;
        logic [1:0] free_cnt;
        logic hold_off;
        logic pin_oe;
    } isact_state_t;

    isact_state_t st_r;
    isact_state_t st_nxt;
    isact_pins_t pins_async;
    isact_pins_t pins;

    // ****************************************
    // Pin synchronisation
    // ****************************************
    assign pins_async.bclk = bit_clk_in;
    assign pins_async.fsync = frame_sync_in;
    assign pins_async.line = serial_port_pin_in_i;

    isact_sync2 #(.WIDTH($bits(isact_pins_t))) u_sync
    (
        .clk(clk),
        .rst(rst),
        .async_in(pins_async),
        .sync_out(pins)
    );

    // ****************************************
    // Helper terms
    // ****************************************
    logic bclk_rise;
    logic bclk_fall;
    logic slave;
    logic act_hold;
    logic req;
    logic [BIT_CNT_W-1:0] cur_pos;
    logic in_tad_rx;
    logic in_tad_tx;
    logic [1:0] rx_idx;
    logic [1:0] tx_idx;
    logic frame_end;
    logic [2:0] tad_full;
    logic addr_match;
    logic [1:0] free_new;
    logic may_start;
    logic tic_low;
    logic contending;
    logic own_rx_bit;

    // Edges of the bit clock seen on the system clock
    assign bclk_rise = pins.bclk & ~st_r.bclk_d;
    assign bclk_fall = ~pins.bclk & st_r.bclk_d;
    assign slave = (st_r.cfg.mode == MODE_SLAVE);
    assign act_hold = slave & st_r.cfg.act;
    // Software request bit and D-channel controller share one arbiter
    assign req = st_r.cfg.tic_en & (st_r.cfg.bar | d_channel_link_controller_req);

    // Bit position of the sample taken on this rising edge
    assign cur_pos = pins.fsync ? '0 : st_r.bit_cnt;
    assign in_tad_rx = (cur_pos >= TIC_TAD_POS) && (cur_pos <= TIC_TAD_LAST);
    assign in_tad_tx = (st_r.bit_cnt >= TIC_TAD_POS) && (st_r.bit_cnt <= TIC_TAD_LAST);
    assign rx_idx = 2'(cur_pos - TIC_TAD_POS);
    assign tx_idx = 2'(st_r.bit_cnt - TIC_TAD_POS);
    assign frame_end = bclk_rise && (cur_pos == TIC_TAD_LAST);
    // Address goes out most significant bit first
    assign tad_full = {st_r.tad_rx[1:0], pins.line};
    assign addr_match = (tad_full == st_r.cfg.tic_addr);
    assign own_rx_bit = st_r.cfg.tic_addr[2'd2 - rx_idx];
    assign contending = (st_r.arb == ARB_SEND) || (st_r.arb == ARB_CONFIRM) || (st_r.arb == ARB_OWN);

    // Consecutive frames with the bus seen free, saturating
    assign free_new = !st_r.line_bac ? 2'h0 :
                      (st_r.free_cnt == FREE_FRAMES) ? FREE_FRAMES : 2'(st_r.free_cnt + 2'h1);
    // After a release, two free frames are needed before trying again
    assign may_start = st_r.line_bac && (!st_r.hold_off || (free_new == FREE_FRAMES));

    // Level to put on the open-drain line for the coming bit
    always_comb
    begin
        tic_low = 1'b0;
        if ((st_r.bit_cnt == TIC_BAC_POS) && ((st_r.arb == ARB_CONFIRM) || (st_r.arb == ARB_OWN)))
        begin
            tic_low = 1'b1;
        end
        else if (in_tad_tx && contending && !st_r.lost)
        begin
            tic_low = ~st_r.cfg.tic_addr[2'd2 - tx_idx];
        end
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.bclk_d = pins.bclk;
        st_nxt.rdata = '0;

        // Register writes
        if (reg_wr)
        begin
            case (reg_addr)
                REG_PCTL1:
                begin
                    st_nxt.cfg.mode = reg_wdata[PCTL1_MODE_LSB +: 2];
                    st_nxt.cfg.act = reg_wdata[PCTL1_ACT_BIT];
                end
                REG_PCTL3:
                begin
                    st_nxt.cfg.tic_en = reg_wdata[PCTL3_TIC_EN_BIT];
                    st_nxt.cfg.tic_addr = reg_wdata[PCTL3_ADDR_LSB +: 3];
                end
                REG_CCH0:
                begin
                    st_nxt.cfg.bar = reg_wdata[CCH0_BAR_BIT];
                    st_nxt.cfg.ci0_cmd = reg_wdata[CCH0_CMD_LSB +: 7];
                end
                default:
                begin
                    st_nxt.cfg = st_r.cfg;
                end
            endcase
        end

        // Register reads: data stands in the following cycle only
        if (reg_rd)
        begin
            case (reg_addr)
                REG_PCTL1:
                begin
                    st_nxt.rdata[PCTL1_MODE_LSB +: 2] = st_r.cfg.mode;
                    st_nxt.rdata[PCTL1_ACT_BIT] = st_r.cfg.act;
                end
                REG_PCTL3:
                begin
                    st_nxt.rdata[PCTL3_TIC_EN_BIT] = st_r.cfg.tic_en;
                    st_nxt.rdata[PCTL3_ADDR_LSB +: 3] = st_r.cfg.tic_addr;
                end
                REG_PSTAT:
                begin
                    st_nxt.rdata[PSTAT_TREQ_BIT] = st_r.treq;
                end
                REG_CCH0:
                begin
                    st_nxt.rdata[CCH0_BAR_BIT] = st_r.cfg.bar;
                    st_nxt.rdata[CCH0_CMD_LSB +: 7] = st_r.cfg.ci0_cmd;
                end
                REG_LSTAT:
                begin
                    st_nxt.rdata[LSTAT_ACTIVE_BIT] = (st_r.link == LINK_ACTIVE);
                    st_nxt.rdata[LSTAT_GRANT_BIT] = (st_r.arb == ARB_OWN);
                    st_nxt.rdata[LSTAT_BAC_BIT] = st_r.line_bac;
                    st_nxt.rdata[LSTAT_HOLD_BIT] = st_r.hold_off;
                end
                default:
                begin
                    st_nxt.rdata = '0;
                end
            endcase
        end

        // Status read clears the flag; a new event in the same cycle wins
        if (reg_rd && (reg_addr == REG_PSTAT))
        begin
            st_nxt.treq = 1'b0;
        end

        // Time since last bit clock rise, counted on the system clock so it survives a stopped bus
        if (bclk_rise)
        begin
            st_nxt.loss_cnt = '0;
        end
        else if (st_r.loss_cnt != LOSS_W'(LOSS_CYCLES))
        begin
            st_nxt.loss_cnt = LOSS_W'(st_r.loss_cnt + 1'b1);
        end

        // Link activation state
        case (st_r.link)
            LINK_DEACT:
            begin
                if (slave && bclk_rise)
                begin
                    st_nxt.link = LINK_ACTIVE;
                    st_nxt.treq = 1'b1;
                end
            end
            LINK_ACTIVE:
            begin
                if (!slave || (st_nxt.loss_cnt == LOSS_W'(LOSS_CYCLES)))
                begin
                    st_nxt.link = LINK_DEACT;
                end
            end
            default:
            begin
                st_nxt.link = LINK_DEACT;
            end
        endcase

        // Bit position and TIC field sampling at the receive strobe point
        if (bclk_rise)
        begin
            st_nxt.bit_cnt = BIT_CNT_W'(cur_pos + 1'b1);
            if (cur_pos == TIC_BAC_POS)
            begin
                st_nxt.line_bac = pins.line;
                st_nxt.lost = 1'b0;
            end
            if (in_tad_rx)
            begin
                st_nxt.tad_rx = tad_full;
                // Released a one but the line shows zero: a lower address is winning
                if (contending && own_rx_bit && !pins.line)
                begin
                    st_nxt.lost = 1'b1;
                end
            end
        end

        // Arbitration, evaluated once per frame after the last address bit
        if (!(slave && (st_r.link == LINK_ACTIVE) && st_r.cfg.tic_en))
        begin
            st_nxt.arb = ARB_IDLE;
        end
        else if (frame_end)
        begin
            st_nxt.free_cnt = free_new;
            case (st_r.arb)
                ARB_IDLE:
                begin
                    if (req)
                    begin
                        st_nxt.arb = ARB_WAIT;
                    end
                end
                ARB_WAIT:
                begin
                    if (!req)
                    begin
                        st_nxt.arb = ARB_IDLE;
                    end
                    else if (may_start)
                    begin
                        st_nxt.arb = ARB_SEND;
                        st_nxt.hold_off = 1'b0;
                    end
                end
                ARB_SEND:
                begin
                    if (!req)
                    begin
                        st_nxt.arb = ARB_IDLE;
                    end
                    else if (addr_match)
                    begin
                        st_nxt.arb = ARB_CONFIRM;
                    end
                    else
                    begin
                        st_nxt.arb = ARB_WAIT;
                    end
                end
                ARB_CONFIRM:
                begin
                    if (!req)
                    begin
                        st_nxt.arb = ARB_IDLE;
                        st_nxt.hold_off = 1'b1;
                    end
                    else if (addr_match)
                    begin
                        st_nxt.arb = ARB_OWN;
                    end
                    else
                    begin
                        st_nxt.arb = ARB_WAIT;
                    end
                end
                ARB_OWN:
                begin
                    // Held while either the request bit or the D channel still needs the bus
                    if (!req)
                    begin
                        st_nxt.arb = ARB_IDLE;
                        st_nxt.hold_off = 1'b1;
                    end
                end
                default:
                begin
                    st_nxt.arb = ARB_IDLE;
                end
            endcase
        end

        // Open-drain enable: activation request overrides, released while deactivated
        if (act_hold)
        begin
            st_nxt.pin_oe = 1'b1;
        end
        else if (st_r.link != LINK_ACTIVE)
        begin
            st_nxt.pin_oe = 1'b0;
        end
        else if (bclk_fall)
        begin
            st_nxt.pin_oe = tic_low;
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st_r.link <= LINK_DEACT;
            st_r.arb <= ARB_IDLE;
            st_r.cfg.mode <= MODE_RST;
            st_r.cfg.act <= 1'b0;
            st_r.cfg.tic_en <= 1'b0;
            st_r.cfg.tic_addr <= TIC_ADDR_RST;
            st_r.cfg.bar <= 1'b0;
            st_r.cfg.ci0_cmd <= CCH0_CMD_RST;
            st_r.treq <= 1'b0;
            st_r.rdata <= '0;
            st_r.bclk_d <= 1'b0;
            st_r.loss_cnt <= '0;
            st_r.bit_cnt <= '0;
            st_r.line_bac <= 1'b0;
            st_r.tad_rx <= '0;
            st_r.lost <= 1'b0;
            st_r.free_cnt <= '0;
            st_r.hold_off <= 1'b0;
            st_r.pin_oe <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // Open drain: only ever pulls low
    assign serial_port_pin_in_o = 1'b0;
    assign serial_port_pin_in_oe = st_r.pin_oe;
    // Downstream-facing line is not driven by this block in slave mode
    assign serial_port_pin_out_o = 1'b0;
    assign serial_port_pin_out_oe = 1'b0;
    assign tic_bus_granted = (st_r.arb == ARB_OWN);
    assign command_channel0_tx_code = st_r.cfg.ci0_cmd;
    assign link_active = (st_r.link == LINK_ACTIVE);
    assign timing_request_irq = st_r.treq;
    assign reg_rdata = st_r.rdata;
endmodule

//--- tb/isact_chk_sva.sv
// Purpose: Port checker for the IOM-2 slave activation and TIC arbiter.
// Assumes: One 40 MHz domain; the raw bit clock is sampled here.
// Notes: Loss bounds leave room for the two-flop sync and edge detect.
`timescale 1ns/1ps
module isact_chk
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic bit_clk_in,
    input wire logic serial_port_pin_in_o,
    input wire logic serial_port_pin_out_oe,
    input wire logic tic_bus_granted,
    input wire logic link_active,
    input wire logic timing_request_irq
);
    logic [5:0] quiet_r;
    logic bclk_d_r;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Cycles since the last raw bit clock rise, saturating so it cannot wrap
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            quiet_r <= 6'h3f;
            bclk_d_r <= 1'b0;
        end
        else
        begin
            bclk_d_r <= bit_clk_in;
            quiet_r <= (bit_clk_in && !bclk_d_r) ? 6'h00 : ((quiet_r == 6'h3f) ? quiet_r : quiet_r + 6'h01);
        end
    end
    property p_loss_late; $fell(link_active) |-> quiet_r >= 6'h18; endproperty
    a_loss_late: assert property (p_loss_late) else $error("link dropped while clock ran");
    property p_loss_fast; quiet_r >= 6'h22 |-> !link_active; endproperty
    a_loss_fast: assert property (p_loss_fast) else $error("link kept after clock loss");
    property p_act_irq; $rose(link_active) |-> timing_request_irq; endproperty
    a_act_irq: assert property (p_act_irq) else $error("activation without timing flag");
    property p_irq_link; $rose(timing_request_irq) |-> link_active; endproperty
    a_irq_link: assert property (p_irq_link) else $error("timing flag without clock");
    property p_out_idle; serial_port_pin_out_oe == 1'b0; endproperty
    a_out_idle: assert property (p_out_idle) else $error("second data pin driven");
    property p_od_low; serial_port_pin_in_o == 1'b0; endproperty
    a_od_low: assert property (p_od_low) else $error("open drain drives high");
    property p_stat_rd; reg_rd && reg_addr == 8'h08 && timing_request_irq |=> reg_rdata == 8'h40; endproperty
    a_stat_rd: assert property (p_stat_rd) else $error("status read lost flag");
    property p_stat_clr; reg_rd && reg_addr == 8'h08 |=> ##1 !timing_request_irq; endproperty
    a_stat_clr: assert property (p_stat_clr) else $error("status read kept flag");
    property p_grant_link; !link_active && !$past(link_active) |-> !tic_bus_granted; endproperty
    a_grant_link: assert property (p_grant_link) else $error("grant while deactivated");
endmodule

//--- tb/isact_upstream.sv
// Purpose: Upstream layer-1 device plus one rival on the shared data line.
// Assumes: 96 bit frames; 200 ns bit clock, phase offset from system clock.
// Notes: Clock stands low while stopped; the line idles high by pullup.
`timescale 1ns/1ps
module isact_upstream
(
    input wire logic run,
    input wire logic dut_oe,
    input wire logic busy,
    input wire logic [2:0] tad_pull,
    output logic bclk,
    output logic fsync,
    output logic line
);
    int pos = 0;
    logic pull;
    // A low data line asks for clocks, so starting on it mimics the master
    initial
    begin
        bclk = 1'b0;
        #7;
        forever
        begin
            #100;
            if (run || dut_oe)
            begin
                bclk = 1'b1;
                #100;
                bclk = 1'b0;
                pos = (pos + 1) % 96;
            end
        end
    end
    // Rival holds the bus bit low or sends its address bits, MSB first
    assign pull = (pos == 90 && busy) || (pos >= 93 && tad_pull[95 - pos]);
    assign fsync = (pos == 0);
    assign line = !(dut_oe || pull);
endmodule

//--- tb/isact_top_test.sv
// Purpose: Register-driven bench for activation, clock loss and TIC arbitration.
// Assumes: Frame of 96 bits at 200 ns, about 770 system clocks.
// Notes: Waits are counted in system clocks and bounded.
`timescale 1ns/1ps
module isact_top_test;
    import isact_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic dlc_req = 1'b0;
    logic run = 1'b0;
    logic busy = 1'b0;
    logic [2:0] tad_pull = 3'h0;
    logic [7:0] reg_rdata;
    logic [6:0] code;
    logic bclk, fsync, line, pin_o, pin_oe, out_o, out_oe, grant, link, irq;
    int error_cnt = 0;
    int tests_run = 0;
    always #12.5 clk = ~clk;
    isact_top u_isact_top (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bit_clk_in(bclk), .frame_sync_in(fsync),
        .serial_port_pin_in_i(line), .serial_port_pin_in_o(pin_o), .serial_port_pin_in_oe(pin_oe),
        .serial_port_pin_out_o(out_o), .serial_port_pin_out_oe(out_oe), .d_channel_link_controller_req(dlc_req),
        .tic_bus_granted(grant), .command_channel0_tx_code(code), .link_active(link), .timing_request_irq(irq));
    isact_upstream u_isact_upstream (.run(run), .dut_oe(pin_oe), .busy(busy), .tad_pull(tad_pull), .bclk(bclk),
        .fsync(fsync), .line(line));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: %s got %h", $time, what, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp, what);
    endtask
    // Grant is checked once it settles or the limit runs out
    task automatic wait_grant(input logic want, input int lim);
        for (int n = 0; n < lim && grant !== want; n++)
            @(posedge clk);
        chk({7'h00, grant}, {7'h00, want}, "grant");
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        #2_000_000;
        error_cnt++;
        complete_run();
    end
    initial
    begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd(REG_PCTL1, 8'h01, "ctl1 reset");
        rd(REG_CCH0, 8'h00, "cch0 reset");
        wr(8'h3c, 8'hff);
        rd(8'h3c, 8'h00, "unmapped");
        $display("test reset done");
        wr(REG_PCTL1, 8'h06);
        repeat (2) @(posedge clk);
        #1 chk({7'h00, pin_oe}, 8'h01, "act pull");
        for (int n = 0; n < 100 && irq !== 1'b1; n++)
            @(posedge clk);
        chk({6'h00, link, irq}, 8'h03, "local act");
        rd(REG_PSTAT, 8'h40, "flag set");
        rd(REG_PSTAT, 8'h00, "flag clear");
        run <= 1'b1;
        wr(REG_PCTL1, 8'h02);
        // The pin is let go only at the next bit clock fall, up to one bit time later
        repeat (12) @(posedge clk);
        #1 chk({7'h00, pin_oe}, 8'h00, "act release");
        $display("test local activation done");
        run <= 1'b0;
        repeat (60) @(posedge clk);
        #1 chk({6'h00, link, pin_oe}, 8'h00, "clock loss");
        chk({5'h00, out_o, out_oe, pin_o}, 8'h00, "pins released");
        run <= 1'b1;
        repeat (20) @(posedge clk);
        #1 chk({6'h00, link, irq}, 8'h03, "upstream act");
        rd(REG_PSTAT, 8'h40, "flag set");
        $display("test loss and upstream activation done");
        busy <= 1'b1;
        wr(REG_PCTL3, 8'h0d);
        wr(REG_CCH0, 8'hb2);
        // The written code shows only after the edge that takes the write
        @(posedge clk);
        chk({1'b0, code}, 8'h32, "command code");
        repeat (2400) @(posedge clk);
        wait_grant(1'b0, 1);
        rd(REG_LSTAT, 8'h01, "bus seen taken");
        busy <= 1'b0;
        tad_pull <= 3'h1;
        repeat (2400) @(posedge clk);
        wait_grant(1'b0, 1);
        tad_pull <= 3'h0;
        wait_grant(1'b1, 4000);
        $display("test arbitration done");
        dlc_req <= 1'b1;
        wr(REG_CCH0, 8'h32);
        repeat (1600) @(posedge clk);
        wait_grant(1'b1, 1);
        wr(REG_CCH0, 8'hb2);
        dlc_req <= 1'b0;
        repeat (1600) @(posedge clk);
        wait_grant(1'b1, 1);
        wr(REG_CCH0, 8'h32);
        wait_grant(1'b0, 1600);
        dlc_req <= 1'b1;
        // Own release just seen: bus bit sampled low, hold-off armed
        rd(REG_LSTAT, 8'h09, "hold off");
        repeat (1200) @(posedge clk);
        wait_grant(1'b0, 1);
        wait_grant(1'b1, 4800);
        dlc_req <= 1'b0;
        wait_grant(1'b0, 1600);
        $display("test release done");
        complete_run();
    end
endmodule
bind isact_top isact_chk u_isact_chk (.*);
